/* tb/rx_slicer_amplitude_config_tb_top.sv */
`timescale 1ns/1ps
`include "slicer_defs.svh"
module rx_slicer_amplitude_config_tb_top
  import slicer_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ev = 1'b0;
  rx_phase_t phase = PHASE_WAKEUP;
  amp_sample_t samp = '0;
  logic ctick = 1'b0;
  logic btick = 1'b0;
  amp_measure_t meas = '0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic [7:0] thr;
  wire logic slice;
  wire logic above;
  wire logic below;
  wire logic tmo;
  wire logic acq_done;
  int failures = 0;
  int compares = 0;
  logic [31:0] rd;
  // Rows of register index, write data and the value expected on read back.
  logic [7:0] row_idx [9] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h30, 8'h31, 8'h3f};
  logic [31:0] row_wd [9] = '{32'h0000_0123, 32'h13, 32'h80, 32'h5c, 32'ha6, 32'h39, 32'h5a,
    32'h77, 32'h55};
  logic [31:0] row_exp [9] = '{32'h23, 32'h13, 32'h80, 32'h5c, 32'ha6, 32'h39, 32'h5a, 32'h0,
    32'h0};
  logic [7:0] acq_v [3] = '{8'h50, 8'h24, 8'h66};

  initial
  begin
    forever #10 clk = ~clk;
  end

  rx_slicer_amplitude_config rx_slicer_amplitude_config_i (
    .i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_rx_event_start(ev), .i_phase(phase), .i_sample(samp), .i_chip_tick(ctick),
    .i_bit_tick(btick), .i_amp_measure(meas), .o_slicer_threshold(thr),
    .o_slice_data(slice), .o_amp_above(above), .o_amp_below(below),
    .o_chip_timeout(tmo), .o_acq_done(acq_done)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; the wait loops rely on the watchdog to end a hang.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rx_event();
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic bit_tick(input logic [7:0] v);
    @(posedge clk);
    samp <= '{valid: 1'b1, value: v};
    btick <= 1'b1;
    @(posedge clk);
    samp <= '{valid: 1'b0, value: v};
    btick <= 1'b0;
  endtask

  task automatic measure(input logic [15:0] m, input logic a, input logic b);
    @(posedge clk);
    meas <= '{valid: 1'b1, value: m};
    @(posedge clk);
    meas <= '{valid: 1'b0, value: m};
    @(posedge clk);
    chk("amp_above", {31'h0, a}, {31'h0, above});
    chk("amp_below", {31'h0, b}, {31'h0, below});
  endtask

  task automatic sample(input logic [7:0] v);
    @(posedge clk);
    samp <= '{valid: 1'b1, value: v};
    @(posedge clk);
    samp <= '{valid: 1'b0, value: v};
    @(posedge clk);
  endtask

  task automatic chip_tick();
    @(posedge clk);
    ctick <= 1'b1;
    @(posedge clk);
    ctick <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial
  begin
    int n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk("thr_after_reset", 32'h0, {24'h0, thr});
    bus(1'b0, `IDX_EDGE_PEAK, 32'h0);
    chk("edge_peak_reset", 32'h0, rd);
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b1, row_idx[i], row_wd[i]);
      bus(1'b0, row_idx[i], 32'h0);
      chk("reg_readback", row_exp[i], rd);
    end
    // Init from register on every event, code 01 with a held level threshold.
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h14);
    rx_event();
    chk("thr_init_reg", 32'h5a, {24'h0, thr});
    bus(1'b1, `IDX_INIT_VALUE, 32'h33);
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h10);
    rx_event();
    chk("thr_no_init", 32'h5a, {24'h0, thr});
    // Each averaging length with a constant sample gives that sample as result.
    for (int l = 1; l < 4; l++)
    begin
      bus(1'b1, `IDX_WAKEUP_CTL, 32'h18 | l);
      rx_event();
      for (int k = 0; k < (1 << l); k++)
        bit_tick(acq_v[l - 1]);
      n = 0;
      while (acq_done !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      chk("acq_done_seen", 32'h1, {31'h0, acq_done});
      chk("thr_acq", {24'h0, acq_v[l - 1]}, {24'h0, thr});
      bus(1'b0, `IDX_INIT_VALUE, 32'h0);
      chk("init_from_acq", {24'h0, acq_v[l - 1]}, rd);
    end
    // Unequal pair averaged over two bits.
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h19);
    rx_event();
    bit_tick(8'h40);
    bit_tick(8'h60);
    repeat (6) @(posedge clk);
    chk("thr_acq_pair", 32'h50, {24'h0, thr});
    // The data phase uses its own control copy.
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h10);
    bus(1'b1, `IDX_DATA_CTL, 32'h14);
    bus(1'b1, `IDX_INIT_VALUE, 32'h3c);
    phase <= PHASE_DATA;
    rx_event();
    chk("thr_data_phase", 32'h3c, {24'h0, thr});
    phase <= PHASE_WAKEUP;
    // Upper decodes to 5 << 1 = 10, lower to 3 << 1 = 6.
    bus(1'b1, `IDX_UPPER_AMP, 32'h15);
    bus(1'b1, `IDX_LOWER_AMP, 32'h13);
    rx_event();
    measure(16'd11, 1'b1, 1'b0);
    measure(16'd10, 1'b0, 1'b0);
    measure(16'd5, 1'b0, 1'b1);
    measure(16'd6, 1'b0, 1'b0);
    // Short low-pass filter moves a quarter of the error per sample.
    bus(1'b1, `IDX_INIT_VALUE, 32'h40);
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h24);
    rx_event();
    chk("thr_lpf_init", 32'h40, {24'h0, thr});
    sample(8'h80);
    chk("thr_lpf_short", 32'h50, {24'h0, thr});
    chk("slice_level", 32'h1, {31'h0, slice});
    bus(1'b0, `IDX_THRESHOLD, 32'h0);
    chk("thr_readback", 32'h50, rd);
    // Long filter moves a sixteenth of the error per sample.
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h34);
    rx_event();
    sample(8'h80);
    chk("thr_lpf_long", 32'h44, {24'h0, thr});
    // Edge slicer against half the expected peak.
    bus(1'b1, `IDX_EDGE_PEAK, 32'h20);
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h00);
    rx_event();
    sample(8'h10);
    chk("slice_edge_fall", 32'h0, {31'h0, slice});
    sample(8'h40);
    chk("slice_edge_rise", 32'h1, {31'h0, slice});
    sample(8'h38);
    chk("slice_edge_hold", 32'h1, {31'h0, slice});
    sample(8'h10);
    chk("slice_edge_fall2", 32'h0, {31'h0, slice});
    // Gap field 0: the second chip without a transition times out.
    chip_tick();
    chk("tmo_first_chip", 32'h0, {31'h0, tmo});
    chip_tick();
    chk("tmo_second_chip", 32'h1, {31'h0, tmo});
    @(posedge clk);
    chk("tmo_one_cycle", 32'h0, {31'h0, tmo});
    // A timeout mid-acquisition discards the partial sum.
    bus(1'b1, `IDX_WAKEUP_CTL, 32'h1f);
    rx_event();
    repeat (3) bit_tick(8'h10);
    chip_tick();
    chip_tick();
    repeat (8) bit_tick(8'h70);
    repeat (6) @(posedge clk);
    chk("thr_acq_restart", 32'h70, {24'h0, thr});
    stop_test();
  end
endmodule

/* verilog/rx_slicer_amplitude_config.sv */
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "slicer_defs.svh"
module rx_slicer_amplitude_config
  import slicer_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_rx_event_start,
  input wire rx_phase_t i_phase,
  input wire amp_sample_t i_sample,
  input wire logic i_chip_tick,
  input wire logic i_bit_tick,
  input wire amp_measure_t i_amp_measure,
  output logic [7:0] o_slicer_threshold,
  output logic o_slice_data,
  output logic o_amp_above,
  output logic o_amp_below,
  output logic o_chip_timeout,
  output logic o_acq_done
);

  function automatic logic [19:0] decode_threshold(input logic [7:0] r);
    logic [19:0] mant;
    mant = {16'h0000, r[`MANT_MSB:`MANT_LSB]};
    decode_threshold = mant << r[`EXP_MSB:`EXP_LSB];
  endfunction

  function automatic slicer_ctl_t phase_ctl(input rx_phase_t ph, input slicer_ctl_t w,
                                            input slicer_ctl_t p, input slicer_ctl_t d);
    phase_ctl = (ph == PHASE_PREAMBLE) ? p : ((ph == PHASE_DATA) ? d : w);
  endfunction

  logic [7:0] upper_amplitude_threshold;
  logic [7:0] lower_amplitude_threshold;
  logic [7:0] edge_peak_reference;
  slicer_ctl_t wakeup_slicer_control;
  slicer_ctl_t preamble_slicer_control;
  slicer_ctl_t data_slicer_control;
  logic [7:0] slicer_init_value;

  // Settings captured at the start of a receive event.
  logic [7:0] ev_upper;
  logic [7:0] ev_lower;
  logic [7:0] ev_edge;
  slicer_ctl_t ev_wakeup;
  slicer_ctl_t ev_preamble;
  slicer_ctl_t ev_data;
  logic event_armed;

  logic dp_write;
  logic [7:0] dp_idx;
  logic [7:0] threshold_frac;
  logic [7:0] prev_sample;
  logic [2:0] chip_count;
  acq_state_t acq_state;
  logic [10:0] acq_sum;
  logic [3:0] acq_count;
  logic [7:0] acq_result;

  wire addr_phase = i_hsel & i_htrans[1] & i_hready;
  wire addr_mapped = (i_haddr[31:10] == 22'h000000);
  wire [7:0] addr_idx = i_haddr[9:2];
  wire wr_upper = dp_write & (dp_idx == `IDX_UPPER_AMP);
  wire wr_lower = dp_write & (dp_idx == `IDX_LOWER_AMP);
  wire wr_edge = dp_write & (dp_idx == `IDX_EDGE_PEAK);
  wire wr_wakeup = dp_write & (dp_idx == `IDX_WAKEUP_CTL);
  wire wr_preamble = dp_write & (dp_idx == `IDX_PREAMBLE_CTL);
  wire wr_data = dp_write & (dp_idx == `IDX_DATA_CTL);
  wire wr_init = dp_write & (dp_idx == `IDX_INIT_VALUE);
  wire [7:0] wbyte = i_hwdata[7:0];

  // A read right behind a write to the same word sees the new value.
  wire fwd = dp_write & (dp_idx == addr_idx);
  wire [7:0] status_byte = {acq_state != ACQ_IDLE, o_amp_above, o_amp_below, o_slice_data,
                            o_chip_timeout, 1'b0, i_phase};
  wire [7:0] rd_reg =
    (addr_idx == `IDX_UPPER_AMP) ? upper_amplitude_threshold :
    (addr_idx == `IDX_LOWER_AMP) ? lower_amplitude_threshold :
    (addr_idx == `IDX_EDGE_PEAK) ? edge_peak_reference :
    (addr_idx == `IDX_WAKEUP_CTL) ? wakeup_slicer_control :
    (addr_idx == `IDX_PREAMBLE_CTL) ? preamble_slicer_control :
    (addr_idx == `IDX_DATA_CTL) ? data_slicer_control :
    (addr_idx == `IDX_INIT_VALUE) ? slicer_init_value :
    (addr_idx == `IDX_THRESHOLD) ? o_slicer_threshold :
    (addr_idx == `IDX_STATUS) ? status_byte : 8'h00;
  // Only writable words are forwarded, so a write to a hole still reads back as zero.
  wire host_reg = ((addr_idx >= `IDX_UPPER_AMP) & (addr_idx <= `IDX_DATA_CTL)) |
                  (addr_idx == `IDX_INIT_VALUE);
  wire [7:0] rd_byte = !addr_mapped ? 8'h00 : ((fwd & host_reg) ? wbyte : rd_reg);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      dp_write <= addr_phase & i_hwrite & addr_mapped;
      dp_idx <= addr_idx;
      if (addr_phase & !i_hwrite)
        o_hrdata <= {24'h000000, rd_byte};
    end
  end

  // Host-visible configuration registers; writes land in the data phase.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      upper_amplitude_threshold <= `RST_AMP_TH;
      lower_amplitude_threshold <= `RST_AMP_TH;
      edge_peak_reference <= `RST_EDGE_PEAK;
      wakeup_slicer_control <= `RST_CTL;
      preamble_slicer_control <= `RST_CTL;
      data_slicer_control <= `RST_CTL;
    end
    else
    begin
      if (wr_upper)
        upper_amplitude_threshold <= wbyte;
      if (wr_lower)
        lower_amplitude_threshold <= wbyte;
      if (wr_edge)
        edge_peak_reference <= wbyte;
      if (wr_wakeup)
        wakeup_slicer_control <= slicer_ctl_t'(wbyte);
      if (wr_preamble)
        preamble_slicer_control <= slicer_ctl_t'(wbyte);
      if (wr_data)
        data_slicer_control <= slicer_ctl_t'(wbyte);
    end
  end

  // Latching at event start keeps a mid-event write from disturbing the slicer.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ev_upper <= `RST_AMP_TH;
      ev_lower <= `RST_AMP_TH;
      ev_edge <= `RST_EDGE_PEAK;
      ev_wakeup <= `RST_CTL;
      ev_preamble <= `RST_CTL;
      ev_data <= `RST_CTL;
      event_armed <= 1'b0;
    end
    else
    begin
      event_armed <= i_rx_event_start;
      if (i_rx_event_start)
      begin
        ev_upper <= upper_amplitude_threshold;
        ev_lower <= lower_amplitude_threshold;
        ev_edge <= edge_peak_reference;
        ev_wakeup <= wakeup_slicer_control;
        ev_preamble <= preamble_slicer_control;
        ev_data <= data_slicer_control;
      end
    end
  end

  wire slicer_ctl_t act = phase_ctl(i_phase, ev_wakeup, ev_preamble, ev_data);
  wire rx_active = (i_phase != PHASE_IDLE);

  // Amplitude classification against the decoded thresholds.
  wire [19:0] upper_level = decode_threshold(ev_upper);
  wire [19:0] lower_level = decode_threshold(ev_lower);
  // One step is about 6.2 Hz (18.6 Hz wide range) in FSK, 0.00293 dB in ASK.
  wire meas_above = {4'h0, i_amp_measure.value} > upper_level;
  wire meas_below = {4'h0, i_amp_measure.value} < lower_level;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_amp_above <= 1'b0;
      o_amp_below <= 1'b0;
    end
    else if (i_amp_measure.valid)
    begin
      o_amp_above <= meas_above;
      o_amp_below <= meas_below;
    end
  end

  // Chip timeout: more chips without a transition than the gap field allows.
  wire chip_expire = i_chip_tick & (chip_count > act.gap_count);
  wire [8:0] sample_ext = {1'b0, i_sample.value};
  wire [8:0] diff = sample_ext - {1'b0, prev_sample};
  wire [8:0] half_peak = {2'b00, ev_edge[7:1]};
  wire edge_rise = !diff[8] & (diff > half_peak);
  wire edge_fall = diff[8] & ((9'h000 - diff) > half_peak);
  wire level_bit = i_sample.value > o_slicer_threshold;
  wire next_slice = (act.slicer_select == `SEL_EDGE) ?
                    (edge_rise ? 1'b1 : (edge_fall ? 1'b0 : o_slice_data)) :
                    level_bit;
  wire slice_toggle = i_sample.valid & (next_slice != o_slice_data);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_slice_data <= 1'b0;
      prev_sample <= 8'h00;
      chip_count <= 3'd0;
      o_chip_timeout <= 1'b0;
    end
    else
    begin
      o_chip_timeout <= rx_active & chip_expire;
      if (i_sample.valid)
      begin
        o_slice_data <= next_slice;
        prev_sample <= i_sample.value;
      end
      if (slice_toggle | !rx_active | event_armed | chip_expire)
        chip_count <= 3'd0;
      else if (i_chip_tick)
        chip_count <= chip_count + 3'd1;
    end
  end

  // Initial acquisition: average the sample taken at each bit tick.
  wire acq_enable = act.init_mode[1] & (act.acq_length != `ACQ_LEN_NONE);
  wire [3:0] acq_target = 4'h1 << act.acq_length;
  wire [10:0] acq_sum_next = acq_sum + {3'b000, i_sample.value};
  wire acq_last = i_bit_tick & (acq_count + 4'h1 == acq_target);
  wire acq_restart = (act.init_mode == `INIT_ACQ_RESTART) & o_chip_timeout;
  acq_state_t next_acq_state;

  always_comb
  begin
    next_acq_state = acq_state;
    case (acq_state)
      ACQ_IDLE: next_acq_state = (event_armed & acq_enable) ? ACQ_RUN : ACQ_IDLE;
      ACQ_RUN: next_acq_state = (acq_last & !acq_restart) ? ACQ_DONE : ACQ_RUN;
      ACQ_DONE: next_acq_state = ACQ_RUN;
      default: next_acq_state = ACQ_IDLE;
    endcase
    if (!rx_active | !acq_enable)
      next_acq_state = ACQ_IDLE;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      acq_state <= ACQ_IDLE;
      acq_sum <= 11'h000;
      acq_count <= 4'h0;
      acq_result <= 8'h00;
      o_acq_done <= 1'b0;
    end
    else
    begin
      acq_state <= next_acq_state;
      o_acq_done <= (acq_state == ACQ_DONE);
      if (acq_state != ACQ_RUN | acq_restart | acq_last)
      begin
        acq_sum <= 11'h000;
        acq_count <= 4'h0;
      end
      else if (i_bit_tick)
      begin
        acq_sum <= acq_sum_next;
        acq_count <= acq_count + 4'h1;
      end
      if (acq_state == ACQ_RUN & acq_last & !acq_restart)
        acq_result <= 8'(acq_sum_next >> act.acq_length);
    end
  end

  wire acq_write = (acq_state == ACQ_DONE);

  // Hardware result wins over a host write in the same cycle.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      slicer_init_value <= `RST_INIT_VALUE;
    else if (acq_write)
      slicer_init_value <= acq_result;
    else if (wr_init)
      slicer_init_value <= wbyte;
  end

  // Threshold kept as 8.8 fixed point so the slow filter does not stall on rounding.
  wire [15:0] thr_acc = {o_slicer_threshold, threshold_frac};
  wire lpf_on = (act.slicer_select == `SEL_LPF_SHORT) | (act.slicer_select == `SEL_LPF_LONG);
  wire [3:0] lpf_shift = (act.slicer_select == `SEL_LPF_LONG) ?
                         `LPF_SHIFT_LONG : `LPF_SHIFT_SHORT;
  wire signed [16:0] lpf_err = $signed({1'b0, i_sample.value, 8'h00}) - $signed({1'b0, thr_acc});
  wire signed [16:0] lpf_step = lpf_err >>> lpf_shift;
  wire [15:0] lpf_next = 16'($signed({1'b0, thr_acc}) + lpf_step);
  wire init_load = event_armed & (act.init_mode == `INIT_FROM_REG);
  logic [15:0] next_thr;

  always_comb
  begin
    next_thr = thr_acc;
    if (acq_write)
      next_thr = {acq_result, 8'h00};
    else if (init_load)
      next_thr = {slicer_init_value, 8'h00};
    else if (rx_active & lpf_on & i_sample.valid)
      next_thr = lpf_next;
  end

  // Init code 00 and the held slicer fall through to the hold branch above.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_slicer_threshold <= 8'h00;
      threshold_frac <= 8'h00;
    end
    else
    begin
      o_slicer_threshold <= next_thr[15:8];
      threshold_frac <= next_thr[7:0];
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  property p_upper_cmp;
    i_amp_measure.valid & ({4'h0, i_amp_measure.value} > decode_threshold(ev_upper))
      |=> o_amp_above;
  endproperty
  a_upper_cmp: assert property (p_upper_cmp) else $error("upper compare missed");

  property p_lower_cmp;
    i_amp_measure.valid & ({4'h0, i_amp_measure.value} >= decode_threshold(ev_lower))
      |=> !o_amp_below;
  endproperty
  a_lower_cmp: assert property (p_lower_cmp) else $error("lower compare wrong");

  property p_edge_reset;
    $past(i_rst) |-> (edge_peak_reference == 8'h00);
  endproperty
  a_edge_reset: assert property (p_edge_reset) else $error("edge peak not zero");

  property p_init_load;
    init_load & !acq_write |=> o_slicer_threshold == $past(slicer_init_value);
  endproperty
  a_init_load: assert property (p_init_load) else $error("init value not loaded");

  property p_hold;
    rx_active & (act.slicer_select == `SEL_LEVEL_HOLD) & !acq_write & !init_load
      |=> $stable(o_slicer_threshold);
  endproperty
  a_hold: assert property (p_hold) else $error("held threshold moved");

  property p_no_init;
    (act.init_mode == `INIT_NONE) |-> !acq_write & !init_load;
  endproperty
  a_no_init: assert property (p_no_init) else $error("threshold initialized");

  property p_acq_write;
    acq_write |=> (o_slicer_threshold == slicer_init_value) & o_acq_done;
  endproperty
  a_acq_write: assert property (p_acq_write) else $error("result not in both");

  property p_restart;
    (acq_state == ACQ_RUN) & acq_restart |=> (acq_count == 4'h0) & (acq_state != ACQ_DONE);
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");

  property p_acq_len;
    (acq_state == ACQ_RUN) |-> (acq_count < acq_target);
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("averaging too long");

  property p_latch;
    i_rx_event_start |=> (ev_wakeup == $past(wakeup_slicer_control)) &
                         (ev_data == $past(data_slicer_control));
  endproperty
  a_latch: assert property (p_latch) else $error("settings not latched");

  property p_gap;
    o_chip_timeout |-> $past(chip_count) > $past(act.gap_count);
  endproperty
  a_gap: assert property (p_gap) else $error("early chip timeout");

endmodule

/* verilog/slicer_defs.svh */
`ifndef SLICER_DEFS_SVH
`define SLICER_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_UPPER_AMP 8'h28
`define IDX_LOWER_AMP 8'h29
`define IDX_EDGE_PEAK 8'h2a
`define IDX_WAKEUP_CTL 8'h2b
`define IDX_PREAMBLE_CTL 8'h2c
`define IDX_DATA_CTL 8'h2d
`define IDX_INIT_VALUE 8'h30
`define IDX_THRESHOLD 8'h31
`define IDX_STATUS 8'h32

// Threshold register fields.
`define EXP_MSB 7
`define EXP_LSB 4
`define MANT_MSB 3
`define MANT_LSB 0

// Reset values.
`define RST_AMP_TH 8'h00
`define RST_EDGE_PEAK 8'h00
`define RST_CTL 8'h00
`define RST_INIT_VALUE 8'h00

// Slicer select codes.
`define SEL_EDGE 2'b00
`define SEL_LEVEL_HOLD 2'b01
`define SEL_LPF_SHORT 2'b10
`define SEL_LPF_LONG 2'b11

// Threshold initialization codes.
`define INIT_NONE 2'b00
`define INIT_FROM_REG 2'b01
`define INIT_ACQ 2'b10
`define INIT_ACQ_RESTART 2'b11

// Low-pass time constants in chips, as shifts of the filter step.
`define LPF_CHIPS_SHORT 4
`define LPF_CHIPS_LONG 16
`define LPF_SHIFT_SHORT 4'd2
`define LPF_SHIFT_LONG 4'd4

// Acquisition length code for no averaging.
`define ACQ_LEN_NONE 2'b00

`endif

/* verilog/slicer_pkg.sv */
package slicer_pkg;

  typedef struct packed {
    logic [1:0] gap_count;
    logic [1:0] slicer_select;
    logic [1:0] init_mode;
    logic [1:0] acq_length;
  } slicer_ctl_t;

  typedef enum logic [1:0] {
    PHASE_WAKEUP = 2'b00,
    PHASE_PREAMBLE = 2'b01,
    PHASE_DATA = 2'b10,
    PHASE_IDLE = 2'b11
  } rx_phase_t;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_RUN = 2'b01,
    ACQ_DONE = 2'b10
  } acq_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } amp_sample_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } amp_measure_t;

endpackage
